// ==== design/aof_pkg.sv ====
// shared constants and types for the accelerometer output and sample fifo block
// assumes a serial front end that turns host transfers into byte read/write requests
package aof_pkg;
    localparam int AOF_DEPTH  = 32;                  // fifo entries of one xyz sample
    localparam int AOF_AXIS_W = 14;                  // accel axis width
    localparam int AOF_CNT_W  = 6;                   // sample count and watermark width

    // register map
    localparam logic [7:0] ADDR_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH     = 8'h01;
    localparam logic [7:0] ADDR_X_LOW      = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH     = 8'h03;
    localparam logic [7:0] ADDR_Y_LOW      = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH     = 8'h05;
    localparam logic [7:0] ADDR_Z_LOW      = 8'h06;
    localparam logic [7:0] ADDR_FIFO_SETUP = 8'h09;
    localparam logic [7:0] ADDR_RANGE_CFG  = 8'h0E;
    localparam logic [7:0] ADDR_CUTOFF_CFG = 8'h0F;
    localparam logic [7:0] ADDR_MAG_FIRST  = 8'h33;  // magnetic x high
    localparam logic [7:0] ADDR_MAG_LAST   = 8'h38;  // magnetic z low
    localparam logic [7:0] ADDR_STEP       = 8'h01;
    localparam logic [7:0] ADDR_FAST_STEP  = 8'h02;

    // fifo_setup fields
    localparam int SETUP_MODE_LSB = 6;
    localparam logic [1:0] FMODE_OFF  = 2'h0;
    localparam logic [1:0] FMODE_CIRC = 2'h1;
    localparam logic [1:0] FMODE_STOP = 2'h2;
    localparam logic [1:0] FMODE_TRIG = 2'h3;

    // accel_range_cfg and highpass_cutoff_cfg fields
    localparam int RANGE_HPF_BIT   = 4;
    localparam int CUT_HPF_BYP_BIT = 5;
    localparam int CUT_LPF_EN_BIT  = 4;
    localparam logic [7:0] RANGE_CFG_MASK  = 8'h13;
    localparam logic [7:0] CUTOFF_CFG_MASK = 8'h33;
    localparam logic [7:0] CFG_RESET       = 8'h00;

    // left-justified byte split of an axis, and the watermark off value
    localparam int AXIS_HI_LSB          = 6;
    localparam logic [1:0] LOW_PAD      = 2'h0;
    localparam logic [AOF_CNT_W-1:0] WMRK_OFF = 6'h00;

    typedef struct packed {
        logic [AOF_AXIS_W-1:0] x;
        logic [AOF_AXIS_W-1:0] y;
        logic [AOF_AXIS_W-1:0] z;
    } aof_sample_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } aof_mag_t;

    typedef struct packed {
        logic       rd;                              // read one byte
        logic       wr;                              // write one byte
        logic       burst;                           // continue at internal pointer
        logic [7:0] addr;                            // start address when not burst
        logic [7:0] wdata;
    } aof_req_t;
endpackage : aof_pkg

// ==== design/aof_top.sv ====
// sample fifo and the accelerometer output/config register block
// assumes one request per cycle at most, synchronous inputs, and a sample
// source that presents raw and high-pass data together with rate ticks
//
// How it works
// RULE1 - axis samples are 14-bit two's complement, left-justified over high and low byte
// RULE2 - fifo off shows current sample; fifo on shows oldest of up to 32
// RULE3 - burst order x,y,z high then low; fast-read skips low bytes
// RULE4 - a directly addressed low byte returns low data whatever fast-read says
// RULE5 - hybrid combined burst gives accel then magnetic bytes, fast-read high only
// RULE6 - with fifo on, 0x01 gives fifo head and direct 0x02-0x06 read zero
// RULE7 - auto-increment spans status and six output bytes, 0x00 to 0x06
// RULE8 - mode 00 off, 01 circular, 10 stop when full, 11 trigger
// RULE9 - flush on fifo off, on auto wake/sleep rate change, on standby to active
// RULE10 - writing mode 00 clears overflow, watermark flag and count
// RULE11 - overflow flag sets when count reaches 32
// RULE12 - watermark flag while count at or above watermark; zero watermark disables
// RULE13 - in trigger mode the watermark gives the retained pre-trigger samples
// RULE14 - host writes watermark only in standby, never switches between nonzero modes
// RULE15 - fifo keeps accepting samples past the watermark
// RULE16 - push at active rate tick, or sleep rate tick while auto-sleep holds
// RULE17 - a fifo read returns oldest sample, removes it, count drops by one
// RULE18 - next fifo read starts at x of the following entry; unread y,z lost
// RULE19 - trigger mode circular until trigger, then fills and drops newest when full
// RULE20 - 2-bit range field selects 2, 4 or 8 g; 11 reserved
// RULE21 - high-pass enable bit routes filtered data to the outputs
// RULE22 - cutoff bits bypass tap high-pass and enable tap low-pass
// RULE23 - cutoff choice scales corner; hybrid operation halves it
// RULE24 - each fifo entry holds x, y and z taken at one rate tick

// plain first-in first-out store with valid/ready on both sides
module aof_fifo #(
    parameter int WIDTH = 42,
    parameter int DEPTH = 32
) (
    input  wire logic                       core_clk_i,  // block clock
    input  wire logic                       rst_b_i,     // sync reset, low
    input  wire logic                       flush_i,     // empty the store
    input  wire logic                       in_valid_i,  // write offered
    output logic                            in_ready_o,  // room or pop this cycle
    input  wire logic [WIDTH-1:0]           in_data_i,   // write word
    output logic                            out_valid_o, // head present
    input  wire logic                       out_ready_i, // pop head
    output logic [WIDTH-1:0]                out_data_o,  // head word
    output logic [$clog2(DEPTH+1)-1:0]      count_o      // stored words
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [IW-1:0] LAST_IDX  = IW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT  = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE   = CW'(1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [IW-1:0]    wr_idx_reg;
    logic [IW-1:0]    rd_idx_reg;
    logic [CW-1:0]    count_reg;
    logic             push;
    logic             pop;

    // a full store still takes a word when the head leaves in the same cycle
    assign in_ready_o  = (count_reg != FULL_CNT) || out_ready_i;
    assign out_valid_o = (count_reg != '0);
    assign push        = in_valid_i && in_ready_o && !flush_i;
    assign pop         = out_ready_i && out_valid_o && !flush_i;
    assign out_data_o  = mem_reg[rd_idx_reg];
    assign count_o     = count_reg;

    // storage
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_reg[wr_idx_reg] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || flush_i) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_idx_reg <= (wr_idx_reg == LAST_IDX) ? '0 : wr_idx_reg + 1'b1;
            end
            if (pop) begin
                rd_idx_reg <= (rd_idx_reg == LAST_IDX) ? '0 : rd_idx_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end
endmodule // aof_fifo

module aof_top
    import aof_pkg::*;
#(
    parameter int DEPTH = AOF_DEPTH
) (
    input  wire logic        core_clk_i,      // block clock, 125 MHz
    input  wire logic        rst_b_i,         // sync reset, low
    input  wire aof_req_t    req_i,           // register request from serial front end
    output logic [7:0]       rdata_o,         // read byte
    output logic             rvalid_o,        // rdata_o valid, one cycle
    input  wire logic [7:0]  status_i,        // sample_ready_status byte
    input  wire aof_sample_t raw_sample_i,    // unfiltered sample
    input  wire aof_sample_t hp_sample_i,     // high-pass filtered sample
    input  wire aof_mag_t    mag_sample_i,    // magnetic sample
    input  wire logic        active_tick_i,   // active_rate sample tick
    input  wire logic        sleep_tick_i,    // sleep rate sample tick
    input  wire logic        sleep_i,         // auto-sleep in effect
    input  wire logic        active_i,        // system_control_one active bit
    input  wire logic        fast_read_i,     // system_control_one fast-read bit
    input  wire logic        hybrid_i,        // hybrid accel plus mag operation
    input  wire logic        hyb_autoinc_i,   // mag_control_two combined burst bit
    input  wire logic        trigger_i,       // fifo trigger event
    output logic [1:0]       range_choice_o,  // full-scale range select
    output logic             hpf_out_en_o,    // output high-pass enabled
    output logic             tap_hpf_byp_o,   // tap high-pass bypass
    output logic             tap_lpf_en_o,    // tap low-pass enable
    output logic [1:0]       cutoff_sel_o,    // high-pass cutoff choice
    output logic [2:0]       corner_shift_o,  // log2 of corner divisor
    output logic [AOF_CNT_W-1:0] fifo_count_o, // stored samples
    output logic             fifo_ovf_o,      // overflow flag
    output logic             fifo_wmrk_o      // watermark flag
);
    localparam int SW = $bits(aof_sample_t);
    localparam logic [AOF_CNT_W-1:0] FULL_CNT = AOF_CNT_W'(DEPTH);

    logic [1:0]           mode_reg;
    logic [AOF_CNT_W-1:0] wmrk_reg;
    logic [7:0]           range_reg;
    logic [7:0]           cutoff_reg;
    logic [7:0]           ptr_reg;
    logic [7:0]           rdata_reg;
    logic                 rvalid_reg;
    logic                 ovf_reg;
    logic                 wmk_reg;
    logic                 trig_reg;
    logic                 fifo_burst_reg;
    logic                 sleep_prev_reg;
    logic                 active_prev_reg;
    aof_sample_t          cur_reg;
    aof_sample_t          shadow_reg;
    aof_sample_t          sel_sample;
    aof_sample_t          head;
    logic [7:0]           addr_eff;
    logic [7:0]           rd_byte;
    logic                 fifo_on;
    logic                 tick;
    logic                 flush;
    logic                 circ;
    logic [AOF_CNT_W-1:0] limit;
    logic                 drop;
    logic                 host_pop;
    logic                 in_ready;
    logic                 out_valid;
    logic                 mode_wr;
    logic [SW-1:0]        head_bits;

    // high or low byte of one left-justified axis
    function automatic logic [7:0] axis_byte(input logic [AOF_AXIS_W-1:0] d, input logic low);
        return low ? {d[AXIS_HI_LSB-1:0], LOW_PAD} : d[AOF_AXIS_W-1:AXIS_HI_LSB]; // RULE1
    endfunction

    // byte of an accel sample at an output address
    function automatic logic [7:0] sample_byte(input aof_sample_t s, input logic [7:0] a);
        case (a)
            ADDR_X_HIGH: return axis_byte(s.x, 1'b0);
            ADDR_X_LOW:  return axis_byte(s.x, 1'b1);
            ADDR_Y_HIGH: return axis_byte(s.y, 1'b0);
            ADDR_Y_LOW:  return axis_byte(s.y, 1'b1);
            ADDR_Z_HIGH: return axis_byte(s.z, 1'b0);
            ADDR_Z_LOW:  return axis_byte(s.z, 1'b1);
            default:     return '0;
        endcase
    endfunction

    // byte of the magnetic sample, big-endian per axis
    function automatic logic [7:0] mag_byte(input aof_mag_t m, input logic [7:0] a);
        logic [7:0] i;
        i = a - ADDR_MAG_FIRST;
        case (i)
            8'h00:   return m.x[15:8];
            8'h01:   return m.x[7:0];
            8'h02:   return m.y[15:8];
            8'h03:   return m.y[7:0];
            8'h04:   return m.z[15:8];
            8'h05:   return m.z[7:0];
            default: return '0;
        endcase
    endfunction

    // auto-increment: fast-read steps over low bytes, hybrid burst runs on into mag
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast,
                                             input logic hyb);
        logic in_acc;
        logic in_mag;
        in_acc = (a >= ADDR_X_HIGH) && (a <= ADDR_Z_LOW);
        in_mag = (a >= ADDR_MAG_FIRST) && (a <= ADDR_MAG_LAST);
        if (in_acc && ((fast && a >= ADDR_Z_HIGH) || a == ADDR_Z_LOW)) begin
            return hyb ? ADDR_MAG_FIRST : ADDR_STATUS;               // RULE7 RULE5
        end else if (in_mag && ((fast && a >= ADDR_MAG_LAST - ADDR_STEP) ||
                                a == ADDR_MAG_LAST)) begin
            return ADDR_STATUS;                                      // RULE5
        end else if ((in_acc || in_mag) && fast) begin
            return a + ADDR_FAST_STEP;                               // RULE3
        end else begin
            return a + ADDR_STEP;                                    // RULE3 RULE7
        end
    endfunction

    assign fifo_on   = (mode_reg != FMODE_OFF);
    assign addr_eff  = req_i.burst ? ptr_reg : req_i.addr;
    assign mode_wr   = req_i.wr && addr_eff == ADDR_FIFO_SETUP;
    assign head      = aof_sample_t'(head_bits);
    assign sel_sample = range_reg[RANGE_HPF_BIT] ? hp_sample_i : raw_sample_i; // RULE21

    // sample clock follows the rate that is in force
    assign tick = sleep_i ? sleep_tick_i : active_tick_i;                   // RULE16

    // flush on disable, rate switch and start of activity
    assign flush = !fifo_on || (sleep_i != sleep_prev_reg) ||
                   (active_i && !active_prev_reg);                          // RULE9

    // circular until triggered; trigger mode keeps only the pre-trigger depth
    assign circ  = (mode_reg == FMODE_CIRC) || (mode_reg == FMODE_TRIG && !trig_reg); // RULE8 RULE19
    assign limit = (mode_reg == FMODE_TRIG && wmrk_reg != WMRK_OFF) ? wmrk_reg : FULL_CNT; // RULE13
    assign drop  = tick && circ && out_valid && fifo_count_o >= limit && !host_pop;
    // a read at the x high byte takes the whole entry off the fifo
    assign host_pop = req_i.rd && fifo_on && out_valid && addr_eff == ADDR_X_HIGH; // RULE17

    aof_fifo #(
        .WIDTH (SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .flush_i     (flush),
        .in_valid_i  (tick && fifo_on),              // RULE15 RULE24
        .in_ready_o  (in_ready),
        .in_data_i   (sel_sample),
        .out_valid_o (out_valid),
        .out_ready_i (host_pop || drop),
        .out_data_o  (head_bits),
        .count_o     (fifo_count_o)
    );

    // edge history for flush detection
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sleep_prev_reg  <= 1'b0;
            active_prev_reg <= 1'b0;
        end else begin
            sleep_prev_reg  <= sleep_i;
            active_prev_reg <= active_i;
        end
    end

    // configuration registers; watermark is only legal in standby, not policed here
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            mode_reg   <= FMODE_OFF;
            wmrk_reg   <= WMRK_OFF;
            range_reg  <= CFG_RESET;
            cutoff_reg <= CFG_RESET;
        end else if (req_i.wr) begin
            case (addr_eff)
                ADDR_FIFO_SETUP: begin
                    mode_reg <= req_i.wdata[SETUP_MODE_LSB +: 2];    // RULE8 RULE14
                    wmrk_reg <= req_i.wdata[AOF_CNT_W-1:0];
                end
                ADDR_RANGE_CFG:  range_reg  <= req_i.wdata & RANGE_CFG_MASK;  // RULE20
                ADDR_CUTOFF_CFG: cutoff_reg <= req_i.wdata & CUTOFF_CFG_MASK; // RULE22
                default: ;
            endcase
        end
    end

    // trigger latch, cleared with every flush
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || flush) begin
            trig_reg <= 1'b0;
        end else if (trigger_i && mode_reg == FMODE_TRIG) begin
            trig_reg <= 1'b1;                                        // RULE19
        end
    end

    // overflow is sticky; the set beats a same-cycle clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ovf_reg <= 1'b0;
        end else if (fifo_on && fifo_count_o == FULL_CNT) begin
            ovf_reg <= 1'b1;                                         // RULE11
        end else if ((mode_wr && req_i.wdata[SETUP_MODE_LSB +: 2] == FMODE_OFF) || !fifo_on) begin
            ovf_reg <= 1'b0;                                         // RULE10
        end
    end

    // watermark level, follows the count
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            wmk_reg <= 1'b0;
        end else begin
            wmk_reg <= fifo_on && wmrk_reg != WMRK_OFF && fifo_count_o >= wmrk_reg; // RULE12
        end
    end

    // current sample for the non-fifo view
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cur_reg <= '0;
        end else if (tick) begin
            cur_reg <= sel_sample;                                   // RULE2
        end
    end

    // popped entry feeds x low, y and z of the same burst only
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            shadow_reg     <= '0;
            fifo_burst_reg <= 1'b0;
        end else if (req_i.rd || req_i.wr) begin
            if (host_pop) begin
                shadow_reg <= head;                                  // RULE18
            end
            fifo_burst_reg <= fifo_on && addr_eff >= ADDR_X_HIGH && addr_eff <= ADDR_Z_LOW &&
                              (host_pop || (req_i.burst && fifo_burst_reg)); // RULE18
        end
    end

    // read byte selection
    always_comb begin
        rd_byte = '0;
        case (addr_eff)
            ADDR_STATUS: rd_byte = fifo_on ? {ovf_reg, wmk_reg, fifo_count_o} : status_i;
            ADDR_X_HIGH: rd_byte = fifo_on ? (out_valid ? sample_byte(head, addr_eff) : '0)
                                           : sample_byte(cur_reg, addr_eff);      // RULE2 RULE6
            ADDR_X_LOW, ADDR_Y_HIGH, ADDR_Y_LOW, ADDR_Z_HIGH, ADDR_Z_LOW: begin
                if (!fifo_on) begin
                    rd_byte = sample_byte(cur_reg, addr_eff);        // RULE4
                end else if (req_i.burst && fifo_burst_reg) begin
                    rd_byte = sample_byte(shadow_reg, addr_eff);     // RULE18
                end else begin
                    rd_byte = '0;                                    // RULE6
                end
            end
            ADDR_FIFO_SETUP: rd_byte = {mode_reg, wmrk_reg};
            ADDR_RANGE_CFG:  rd_byte = range_reg;
            ADDR_CUTOFF_CFG: rd_byte = cutoff_reg;
            default: begin
                if (addr_eff >= ADDR_MAG_FIRST && addr_eff <= ADDR_MAG_LAST) begin
                    rd_byte = mag_byte(mag_sample_i, addr_eff);      // RULE5
                end
            end
        endcase
    end

    // answer one cycle after the request, pointer steps on every access
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ptr_reg    <= ADDR_STATUS;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= req_i.rd;
            if (req_i.rd) begin
                rdata_reg <= rd_byte;
            end
            if (req_i.rd || req_i.wr) begin
                ptr_reg <= next_addr(addr_eff, fast_read_i, hybrid_i && hyb_autoinc_i); // RULE3
            end
        end
    end

    assign rdata_o        = rdata_reg;
    assign rvalid_o       = rvalid_reg;
    assign fifo_ovf_o     = ovf_reg;
    assign fifo_wmrk_o    = wmk_reg;
    assign range_choice_o = range_reg[1:0];                          // RULE20
    assign hpf_out_en_o   = range_reg[RANGE_HPF_BIT];                // RULE21
    assign tap_hpf_byp_o  = cutoff_reg[CUT_HPF_BYP_BIT];             // RULE22
    assign tap_lpf_en_o   = cutoff_reg[CUT_LPF_EN_BIT];              // RULE22
    assign cutoff_sel_o   = cutoff_reg[1:0];
    // hybrid halves the rate, so the corner sits one more octave down
    assign corner_shift_o = {1'b0, cutoff_reg[1:0]} + {2'h0, hybrid_i}; // RULE23

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_mode_off_write;
        mode_wr && req_i.wdata[SETUP_MODE_LSB +: 2] == FMODE_OFF;
    endsequence
    sequence s_cleared;
        ##1 (fifo_count_o == '0 && !ovf_reg && !wmk_reg);
    endsequence

    AST_MODE_OFF_CLEARS: assert property (s_mode_off_write |=> s_cleared) // RULE10
        else $error("mode off write did not clear fifo state");
    AST_DIRECT_LOW_ZERO: assert property (
        req_i.rd && !req_i.burst && fifo_on && req_i.addr >= ADDR_X_LOW &&
        req_i.addr <= ADDR_Z_LOW |=> rdata_o == '0) // RULE6
        else $error("direct output read with fifo on not zero");
    AST_OVF_AT_FULL: assert property (fifo_on && fifo_count_o == FULL_CNT |=> ovf_reg) // RULE11
        else $error("overflow flag missing at full count");
    AST_WMK_SET: assert property (
        fifo_on && wmrk_reg != WMRK_OFF && fifo_count_o >= wmrk_reg && !flush |=> wmk_reg) // RULE12
        else $error("watermark flag missing");
    AST_WMK_OFF: assert property (wmrk_reg == WMRK_OFF && $stable(wmrk_reg) |=> !wmk_reg) // RULE12
        else $error("watermark flag with zero watermark");
    AST_POP_DEC: assert property (
        host_pop && !(tick && fifo_on) && !flush |=> fifo_count_o == $past(fifo_count_o) - 1'b1) // RULE17
        else $error("fifo read did not drop count by one");
    AST_STOP_HOLDS: assert property (
        mode_reg == FMODE_STOP && fifo_count_o == FULL_CNT && !host_pop && !flush
        |=> fifo_count_o == FULL_CNT) // RULE8
        else $error("stop mode lost a stored sample");
    AST_FAST_SKIP: assert property (
        (req_i.rd && fast_read_i && !hybrid_i && addr_eff == ADDR_X_HIGH) |=> ptr_reg == ADDR_Y_HIGH) // RULE3
        else $error("fast read did not skip low byte");
    AST_ACTIVE_FLUSH: assert property ($rose(active_i) |=> fifo_count_o == '0) // RULE9
        else $error("fifo not flushed on standby to active");
endmodule // aof_top

// ==== tb/aof_host.sv ====
// host model: turns byte reads and writes into block requests
// assumes the testbench calls its task from one process only
module aof_host
    import aof_pkg::*;
(
    input  wire logic core_clk_i, // block clock
    output aof_req_t  req_o       // request to the block
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    // request held over its taking edge, dropped right after it
    task automatic xfer(input logic w, b, input logic [7:0] a, d);
        @(posedge core_clk_i);
        req_o <= '{rd: !w, wr: w, burst: b, addr: a, wdata: d};
        @(posedge core_clk_i);
        req_o <= '0;
    endtask
endmodule // aof_host

// ==== tb/accel_output_and_fifo_test.sv ====
// self-checking bench for the sample fifo and output register block
// assumes aof_top and the host model; four rarely used inputs are tied low
module accel_output_and_fifo_test
    import aof_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, tick = 0, fast = 0, act = 0, hyb = 0, trig = 0, rv, ovf, wm;
    logic [7:0] rdata, status = 8'h00;
    logic [1:0] range, sel;
    logic [2:0] corner;
    logic [5:0] cnt;
    logic hpf, byp, lpf;
    aof_sample_t raw = '0, hp = '0, s, q[$];
    aof_req_t req;
    int bad_count = 0, compares = 0;
    logic [15:0] seed = 16'h0028;
    aof_host u_aof_host (.core_clk_i(clk), .req_o(req));
    aof_top u_aof_top (.core_clk_i(clk), .rst_b_i(rst_b), .req_i(req), .rdata_o(rdata),
        .rvalid_o(rv), .status_i(status), .raw_sample_i(raw), .hp_sample_i(hp),
        .mag_sample_i('0), .active_tick_i(tick), .sleep_tick_i(1'b0), .sleep_i(1'b0),
        .active_i(act), .fast_read_i(fast), .hybrid_i(hyb), .hyb_autoinc_i(1'b0),
        .trigger_i(trig), .range_choice_o(range), .hpf_out_en_o(hpf), .tap_hpf_byp_o(byp),
        .tap_lpf_en_o(lpf), .cutoff_sel_o(sel), .corner_shift_o(corner), .fifo_count_o(cnt),
        .fifo_ovf_o(ovf), .fifo_wmrk_o(wm));
    // clock at 8 ns
    initial forever #4 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected byte i of a six-byte burst, left-justified split
    function automatic logic [7:0] pick(input aof_sample_t a, input int i);
        logic [13:0] d;
        d = (i < 2) ? a.x : (i < 4) ? a.y : a.z;
        return i[0] ? {d[5:0], 2'h0} : d[13:6];
    endfunction
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic b, input logic [7:0] a, e);
        u_aof_host.xfer(1'b0, b, a, 8'h00);
        #1;
        chk("rvalid", 8'h01, {7'h00, rv});
        chk("rdata", e, rdata);
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_aof_host.xfer(1'b1, 1'b0, a, d);
    endtask
    // fresh random sample per tick, hp path shows its inverse
    task automatic push(input int n);
        repeat (n) begin
            @(posedge clk);
            seed = lfsr(lfsr(seed));
            s = {seed[13:0], ~seed[13:0], seed[15:2]};
            raw <= s;
            hp <= ~s;
            tick <= 1'b1;
            q.push_back(s);
            @(posedge clk);
            tick <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // a hang is cut short well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(0, ADDR_FIFO_SETUP, 8'h00);
        rd(0, 8'h20, 8'h00);
        push(1);
        s = q.pop_front();
        for (int i = 0; i < 6; i++) rd(i > 0, ADDR_X_HIGH, pick(s, i));
        @(posedge clk) fast <= 1'b1;
        for (int i = 0; i < 3; i++) rd(i > 0, ADDR_X_HIGH, pick(s, 2 * i));
        rd(0, ADDR_Z_LOW, pick(s, 5));
        @(posedge clk) fast <= 1'b0;
        $display("test live outputs done");
        wr(ADDR_RANGE_CFG, 8'h12);
        push(1);
        s = ~q.pop_front();
        chk("range", 8'h12, {3'h0, hpf, 2'h0, range});
        rd(0, ADDR_X_HIGH, pick(s, 0));
        wr(ADDR_RANGE_CFG, 8'h00);
        // all used cutoff bits must come out set; hybrid moves the corner down
        wr(ADDR_CUTOFF_CFG, 8'hFF);
        @(posedge clk) hyb <= 1'b1;
        @(posedge clk) #1 chk("cutoff", 8'h33, {2'h0, byp, lpf, 2'h0, sel});
        chk("corner", 8'h04, {5'h00, corner});
        @(posedge clk) hyb <= 1'b0;
        // watermark only written in standby, mode 00 between modes
        wr(ADDR_FIFO_SETUP, 8'h42);
        @(posedge clk) act <= 1'b1;
        push(3);
        chk("count", 8'hC3, {wm, 1'b1, cnt});
        rd(0, ADDR_Y_LOW, 8'h00);
        s = q.pop_front();
        for (int i = 0; i < 6; i++) rd(i > 0, ADDR_X_HIGH, pick(s, i));
        chk("count", 8'h02, {2'h0, cnt});
        rd(0, ADDR_X_HIGH, pick(q.pop_front(), 0));
        @(posedge clk) act <= 1'b0;
        @(posedge clk) act <= 1'b1;
        @(posedge clk);
        #1 chk("flush", 8'h00, {2'h0, cnt});
        q.delete();
        // while active the watermark keeps its standby value of 2
        wr(ADDR_FIFO_SETUP, 8'h02);
        wr(ADDR_FIFO_SETUP, 8'h82);
        push(33);
        chk("full", 8'hA0, {ovf, 1'b0, cnt});
        rd(0, ADDR_STATUS, 8'hE0);
        rd(0, ADDR_X_HIGH, pick(q[0], 0));
        wr(ADDR_FIFO_SETUP, 8'h02);
        @(posedge clk);
        #1 chk("cleared", 8'h00, {ovf, wm, cnt});
        // trigger mode keeps 3 pre-trigger samples, then fills after the trigger
        @(posedge clk) act <= 1'b0;
        wr(ADDR_FIFO_SETUP, 8'hC3);
        @(posedge clk) act <= 1'b1;
        q.delete();
        push(5);
        chk("pretrig", 8'hC3, {wm, 1'b1, cnt});
        @(posedge clk) trig <= 1'b1;
        @(posedge clk) trig <= 1'b0;
        push(2);
        chk("trig", 8'h05, {2'h0, cnt});
        rd(0, ADDR_X_HIGH, pick(q[2], 0));
        $display("test fifo modes done");
        wrap_up;
    end
endmodule // accel_output_and_fifo_test
